// >>> core/rlvc_top.sv
// reset sequencer, detector flags and status register
`timescale 1ns/1ps
`default_nettype none
module rlvc_top
(
   // clock and power-on reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // options
   input  wire logic [1:0]  detector_setting_in,
   input  wire logic        reset_pin_enable_in,
   // reset pin and comparators (asynchronous)
   input  wire logic        reset_n_pin_in,
   input  wire logic        vdd_below_low_in,
   input  wire logic        vdd_below_mid_in,
   input  wire logic        vdd_below_upper_in,
   // watchdog
   input  wire logic        wdt_overflow_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_write_in,
   input  wire logic        reg_read_in,
   output var  logic [7:0]  reg_rdata_out,
   // core side
   output logic             sys_reset_out,
   output var  logic        core_run_out,
   output var  logic [10:0] fetch_addr_out,
   output var  logic        general_input_out
);
   logic                 pin_low_s;
   logic                 below_low_s;
   logic                 below_mid_s;
   logic                 below_upper_s;
   logic                 det_async;
   logic                 pin_async;
   logic                 det_cond;
   logic                 pin_cond;
   logic                 wdt_cond;
   logic                 hold_cond;
   rlvc_pkg::rlvc_setting_t setting;
   rlvc_pkg::rlvc_state_t   state;
   rlvc_pkg::rlvc_state_t   next_state;
   logic [7:0]           count;
   logic [7:0]           next_count;
   logic [1:0]           cause;
   logic [1:0]           next_cause;
   logic [2:0]           alu_flags;
   logic [2:0]           next_alu_flags;
   logic                 mid_flag;
   logic                 upper_flag;
   logic                 next_mid_flag;
   logic                 next_upper_flag;
   logic                 det_reset_seen;
   logic                 next_det_reset_seen;
   logic [7:0]           next_rdata;
   logic                 next_run;
   logic [10:0]          next_fetch;
   logic                 next_gen_in;
   logic                 hit;

   assign setting = rlvc_pkg::rlvc_setting_t'(detector_setting_in);

   // asynchronous reset requests from the raw inputs
   always_comb
   begin
      if (setting == rlvc_pkg::RLVC_SET_HIGH)
      begin
         det_async = vdd_below_mid_in;
      end
      else
      begin
         det_async = vdd_below_low_in;
      end
   end
   assign pin_async     = reset_pin_enable_in & ~reset_n_pin_in;
   // reset goes out combinationally so it acts with no clock edge
   assign sys_reset_out = rst_in | det_async | pin_async
                          | (state != rlvc_pkg::RLVC_ST_RUN);

   rlvc_sync u_sync_pin
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   (reset_n_pin_in),
      .init_in    (1'b1),
      .level_out  (pin_low_s)
   );
   rlvc_sync u_sync_low
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   (vdd_below_low_in),
      .init_in    (1'b0),
      .level_out  (below_low_s)
   );
   rlvc_sync u_sync_mid
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   (vdd_below_mid_in),
      .init_in    (1'b0),
      .level_out  (below_mid_s)
   );
   rlvc_sync u_sync_upper
   (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .async_in   (vdd_below_upper_in),
      .init_in    (1'b0),
      .level_out  (below_upper_s)
   );

   // synchronised conditions drive the sequencer and the flags
   always_comb
   begin
      if (setting == rlvc_pkg::RLVC_SET_HIGH)
      begin
         det_cond = below_mid_s;
      end
      else
      begin
         det_cond = below_low_s;
      end
      pin_cond  = reset_pin_enable_in & pin_low_s;
      // a watchdog pulse outside run is dropped, a sequence is already on
      wdt_cond  = wdt_overflow_in & (state == rlvc_pkg::RLVC_ST_RUN);
      hold_cond = det_cond | pin_cond;
   end

   // sequencer: hold, init, warm-up, run
   always_comb
   begin
      next_state          = state;
      next_count          = count;
      next_cause          = cause;
      next_det_reset_seen = det_reset_seen;
      unique case (state)
         rlvc_pkg::RLVC_ST_HOLD:
         begin
            if (!hold_cond)
            begin
               next_state = rlvc_pkg::RLVC_ST_INIT;
               next_count = rlvc_pkg::RLVC_INIT_CYC;
            end
         end
         rlvc_pkg::RLVC_ST_INIT:
         begin
            if (count == 8'h01)
            begin
               next_state = rlvc_pkg::RLVC_ST_WARM;
               next_count = rlvc_pkg::RLVC_WARM_CYC;
            end
            else
            begin
               next_count = count - 8'h01;
            end
         end
         rlvc_pkg::RLVC_ST_WARM:
         begin
            if (count == 8'h01)
            begin
               next_state          = rlvc_pkg::RLVC_ST_RUN;
               next_count          = 8'h00;
               next_det_reset_seen = 1'b0;
            end
            else
            begin
               next_count = count - 8'h01;
            end
         end
         rlvc_pkg::RLVC_ST_RUN:
         begin
            if (wdt_cond)
            begin
               next_state = rlvc_pkg::RLVC_ST_INIT;
               next_count = rlvc_pkg::RLVC_INIT_CYC;
               next_cause = rlvc_pkg::RLVC_CAUSE_WDT;
            end
         end
      endcase
      // a new condition at any point restarts the sequence from hold
      if (det_cond)
      begin
         next_state          = rlvc_pkg::RLVC_ST_HOLD;
         next_cause          = rlvc_pkg::RLVC_CAUSE_POWER;
         next_det_reset_seen = 1'b1;
      end
      else if (pin_cond)
      begin
         next_state = rlvc_pkg::RLVC_ST_HOLD;
         next_cause = rlvc_pkg::RLVC_CAUSE_EXT;
      end
   end

   // one register only: other addresses read zero and drop writes
   assign hit = (reg_addr_in == rlvc_pkg::RLVC_OFF_FLAGS);

   // status register, indicator flags and core outputs
   always_comb
   begin
      next_alu_flags = alu_flags;
      next_mid_flag  = 1'b0;
      next_upper_flag = 1'b0;
      if (state != rlvc_pkg::RLVC_ST_RUN)
      begin
         next_alu_flags = rlvc_pkg::RLVC_ALU_RESET;
      end
      else if (reg_write_in && hit)
      begin
         next_alu_flags = {reg_wdata_in[rlvc_pkg::RLVC_BIT_CARRY],
                           reg_wdata_in[rlvc_pkg::RLVC_BIT_DCARRY],
                           reg_wdata_in[rlvc_pkg::RLVC_BIT_ZERO]};
      end
      // flags stay cleared until a detector reset sequence finishes
      if (!det_reset_seen && state == rlvc_pkg::RLVC_ST_RUN)
      begin
         next_mid_flag   = (setting != rlvc_pkg::RLVC_SET_LOW)
                           & below_mid_s;
         next_upper_flag = (setting == rlvc_pkg::RLVC_SET_HIGH)
                           & below_upper_s;
      end
      else
      begin
         next_mid_flag   = 1'b0;
         next_upper_flag = 1'b0;
      end
      next_rdata = 8'h00;
      if (reg_read_in && hit)
      begin
         next_rdata = {cause, upper_flag, mid_flag, 1'b0, alu_flags};
      end
      next_run    = (next_state == rlvc_pkg::RLVC_ST_RUN);
      // the core reloads its program counter from here after every reset
      next_fetch  = fetch_addr_out;
      if (state != rlvc_pkg::RLVC_ST_RUN)
      begin
         next_fetch = rlvc_pkg::RLVC_PC_ZERO;
      end
      next_gen_in = ~reset_pin_enable_in & ~pin_low_s;
   end

   // sequencer registers
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state          <= rlvc_pkg::RLVC_ST_HOLD;
         count          <= 8'h00;
         cause          <= rlvc_pkg::RLVC_CAUSE_POWER;
         det_reset_seen <= 1'b1;
      end
      else
      begin
         state          <= next_state;
         count          <= next_count;
         cause          <= next_cause;
         det_reset_seen <= next_det_reset_seen;
      end
   end

   // status register and core outputs
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         alu_flags         <= rlvc_pkg::RLVC_ALU_RESET;
         mid_flag          <= 1'b0;
         upper_flag        <= 1'b0;
         reg_rdata_out     <= 8'h00;
         core_run_out      <= 1'b0;
         fetch_addr_out    <= rlvc_pkg::RLVC_PC_ZERO;
         general_input_out <= 1'b0;
      end
      else
      begin
         alu_flags         <= next_alu_flags;
         mid_flag          <= next_mid_flag;
         upper_flag        <= next_upper_flag;
         reg_rdata_out     <= next_rdata;
         core_run_out      <= next_run;
         fetch_addr_out    <= next_fetch;
         general_input_out <= next_gen_in;
      end
   end
endmodule : rlvc_top
`default_nettype wire

// >>> core/rlvc_pkg.sv
// shared constants for the reset and low voltage control block
package rlvc_pkg;
   localparam logic [7:0] RLVC_OFF_FLAGS    = 8'h86;
   localparam int         RLVC_BIT_ZERO     = 0;
   localparam int         RLVC_BIT_DCARRY   = 1;
   localparam int         RLVC_BIT_CARRY    = 2;
   localparam int         RLVC_BIT_MID      = 4;
   localparam int         RLVC_BIT_UPPER    = 5;
   localparam int         RLVC_BIT_CAUSE_LO = 6;
   localparam int         RLVC_BIT_CAUSE_HI = 7;
   localparam logic [1:0] RLVC_CAUSE_WDT    = 2'h0;
   localparam logic [1:0] RLVC_CAUSE_POWER  = 2'h2;
   localparam logic [1:0] RLVC_CAUSE_EXT    = 2'h3;
   localparam logic [2:0] RLVC_ALU_RESET    = 3'h0;
   localparam int         RLVC_INIT_NS      = 400;
   localparam int         RLVC_WARM_NS      = 1600;
   localparam int         RLVC_CLK_NS       = 100;
   localparam logic [7:0] RLVC_INIT_CYC     =
      8'((RLVC_INIT_NS + RLVC_CLK_NS - 1) / RLVC_CLK_NS);
   localparam logic [7:0] RLVC_WARM_CYC     =
      8'((RLVC_WARM_NS + RLVC_CLK_NS - 1) / RLVC_CLK_NS);
   localparam logic [10:0] RLVC_PC_ZERO     = 11'h000;

   typedef enum logic [1:0]
   {
      RLVC_SET_LOW  = 2'b00,
      RLVC_SET_MID  = 2'b01,
      RLVC_SET_HIGH = 2'b10
   } rlvc_setting_t;

   typedef enum logic [1:0]
   {
      RLVC_ST_HOLD = 2'b00,
      RLVC_ST_INIT = 2'b01,
      RLVC_ST_WARM = 2'b10,
      RLVC_ST_RUN  = 2'b11
   } rlvc_state_t;
endpackage : rlvc_pkg

// >>> core/rlvc_sync.sv
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module rlvc_sync
(
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   // data
   input  wire logic async_in,
   input  wire logic init_in,
   output var  logic level_out
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic next_level;

   always_comb
   begin
      next_level = level_out;
      if (stage2 == stage3)
      begin
         next_level = stage3;
      end
   end

   // reset loads a fixed zero; the port tied to a literal by the parent sets the input polarity
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stage1    <= 1'b0;
         stage2    <= 1'b0;
         stage3    <= 1'b0;
         level_out <= 1'b0;
      end
      else
      begin
         stage1    <= async_in ^ init_in;
         stage2    <= stage1;
         stage3    <= stage2;
         level_out <= next_level;
      end
   end
endmodule : rlvc_sync
`default_nettype wire

// >>> dv/rlvc_supply_model.sv
// model of the external reset circuit and the supply comparators
`timescale 1ns/1ps
`default_nettype none
module rlvc_supply_model
(
   // clock
   input  wire logic       sys_clk_in,
   // commands from the bench
   input  wire logic       pin_low_req_in,
   input  wire logic       slow_release_in,
   input  wire logic [1:0] supply_level_in,
   // pin and comparators
   output var  logic       reset_n_pin_out,
   output var  logic       below_low_out,
   output var  logic       below_mid_out,
   output var  logic       below_upper_out
);
   logic [3:0] hold_cnt = 4'h0;
   // an rc network lets the pin rise late after the request drops
   always @(posedge sys_clk_in)
   begin
      if (pin_low_req_in)
         hold_cnt <= slow_release_in ? 4'h8 : 4'h0;
      else if (hold_cnt != 4'h0)
         hold_cnt <= hold_cnt - 4'h1;
   end
   always_comb
   begin
      reset_n_pin_out = !pin_low_req_in && hold_cnt == 4'h0;
      // comparators nest: a lower level implies every higher one
      below_low_out   = supply_level_in == 2'h3;
      below_mid_out   = supply_level_in >= 2'h2;
      below_upper_out = supply_level_in >= 2'h1;
   end
endmodule : rlvc_supply_model
`default_nettype wire

// >>> dv/rlvc_monitor.sv
// assertion checker for the reset and low voltage control block
`timescale 1ns/1ps
`default_nettype none
module rlvc_monitor
(
   // clock and reset
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   // watched inputs
   input wire logic [1:0]  detector_setting_in,
   input wire logic        reset_pin_enable_in,
   input wire logic        reset_n_pin_in,
   input wire logic        vdd_below_low_in,
   input wire logic        vdd_below_mid_in,
   input wire logic        wdt_overflow_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic        reg_read_in,
   // watched outputs
   input wire logic [7:0]  reg_rdata_out,
   input wire logic        sys_reset_out,
   input wire logic        core_run_out,
   input wire logic [10:0] fetch_addr_out,
   input wire logic        general_input_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_read;
      reg_read_in && reg_addr_in == 8'h86;
   endsequence
   // watchdog: reset within two edges, run again after the sequence
   sequence s_restart;
      ##[1:2] sys_reset_out ##[18:40] !sys_reset_out;
   endsequence
   chk_low_reset: assert property (vdd_below_low_in |-> sys_reset_out)
      else $error("low supply without reset");
   chk_mid_reset: assert property (detector_setting_in == 2'h2 &&
      vdd_below_mid_in |-> sys_reset_out) else $error("mid reset missed");
   chk_pin_reset: assert property (reset_pin_enable_in &&
      !reset_n_pin_in |-> sys_reset_out) else $error("pin reset missed");
   chk_gpi_off: assert property (reset_pin_enable_in
      |-> !general_input_out) else $error("input port live in reset mode");
   chk_low_flags: assert property (s_read ##0 detector_setting_in == 2'h0
      |=> reg_rdata_out[5:4] == 2'h0) else $error("flags not zero");
   chk_mid_upper: assert property (s_read ##0 detector_setting_in == 2'h1
      |=> !reg_rdata_out[5]) else $error("upper flag in mid setting");
   chk_cause_code: assert property (s_read |=>
      reg_rdata_out[7:6] != 2'h1 && !reg_rdata_out[3])
      else $error("bad cause code");
   chk_warm_time: assert property ($fell(sys_reset_out)
      |-> $past(sys_reset_out, 16)) else $error("sequence too short");
   chk_fetch_zero: assert property ($rose(core_run_out)
      |-> fetch_addr_out == 11'h000) else $error("fetch not at zero");
   chk_wdt_restart: assert property (core_run_out && wdt_overflow_in
      |-> s_restart) else $error("watchdog restart wrong");
endmodule : rlvc_monitor
`default_nettype wire

bind rlvc_top rlvc_monitor u_rlvc_monitor
(
   .sys_clk_in, .rst_in, .detector_setting_in, .reset_pin_enable_in,
   .reset_n_pin_in, .vdd_below_low_in, .vdd_below_mid_in,
   .wdt_overflow_in, .reg_addr_in, .reg_read_in, .reg_rdata_out,
   .sys_reset_out, .core_run_out, .fetch_addr_out, .general_input_out
);

// >>> dv/rlvc_top_tb.sv
// self-checking bench for the reset and low voltage control block
`timescale 1ns/1ps
`default_nettype none
module rlvc_top_tb;
   logic       clk = 1'h0;
   logic       rst = 1'h1;
   logic [1:0] setting = 2'h0;
   logic       pin_en = 1'h1;
   logic       pin_low = 1'h0;
   logic       slow = 1'h0;
   logic [1:0] lvl = 2'h0;
   logic       wdt = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'h0;
   logic       rd = 1'h0;
   wire        pin_n, b_low, b_mid, b_up, sys_rst, run, gpi;
   wire [7:0]  rdata;
   int         num_errors = 0;
   int         compares = 0;
   always #50 clk = ~clk;
   rlvc_supply_model u_rlvc_supply_model
   (
      .sys_clk_in(clk), .pin_low_req_in(pin_low), .slow_release_in(slow),
      .supply_level_in(lvl), .reset_n_pin_out(pin_n),
      .below_low_out(b_low), .below_mid_out(b_mid), .below_upper_out(b_up)
   );
   rlvc_top u_rlvc_top
   (
      .sys_clk_in(clk), .rst_in(rst), .detector_setting_in(setting),
      .reset_pin_enable_in(pin_en), .reset_n_pin_in(pin_n),
      .vdd_below_low_in(b_low), .vdd_below_mid_in(b_mid),
      .vdd_below_upper_in(b_up), .wdt_overflow_in(wdt),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
      .reg_read_in(rd), .reg_rdata_out(rdata), .sys_reset_out(sys_rst),
      .core_run_out(run), .fetch_addr_out(), .general_input_out(gpi)
   );
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic check(input logic [7:0] g, e, input string m);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %0t %s: got %h want %h", $time, m, g, e);
      end
   endtask : check
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, e, input string m);
      addr <= a;
      rd <= 1'h1;
      tick(1);
      rd <= 1'h0;
      tick(1);
      check(rdata, e, m);
   endtask : rd_reg
   task automatic wr_reg(input logic [7:0] a, d);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      tick(1);
      wr <= 1'h0;
   endtask : wr_reg
   task automatic report_and_stop;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic wait_run;
      int i;
      i = 0;
      while (run !== 1'h1 && i < 300)
      begin
         tick(1);
         i++;
      end
      if (run !== 1'h1)
      begin
         num_errors++;
         $display("ERROR %0t run not reached", $time);
         report_and_stop;
      end
   endtask : wait_run
   // options are static, so every change goes through a fresh reset
   task automatic restart(input logic [1:0] s, input logic e);
      rst <= 1'h1;
      setting <= s;
      pin_en <= e;
      tick(2);
      rst <= 1'h0;
      wait_run;
   endtask : restart
   task automatic t_regs;
      rd_reg(8'h86, 8'h80, "cause power");
      wr_reg(8'h86, 8'hff);
      rd_reg(8'h86, 8'h87, "write mask");
      wr_reg(8'h85, 8'hff);
      rd_reg(8'h85, 8'h00, "unmapped");
      $display("t_regs done");
   endtask : t_regs
   task automatic t_pin;
      pin_low <= 1'h1;
      slow <= 1'h1;
      tick(1);
      check(8'(sys_rst), 8'h01, "pin reset");
      tick(30);
      check(8'(run), 8'h00, "pin held");
      pin_low <= 1'h0;
      tick(4);
      check(8'(sys_rst), 8'h01, "slow release");
      wait_run;
      rd_reg(8'h86, 8'hc0, "cause pin");
      $display("t_pin done");
   endtask : t_pin
   task automatic t_wdt;
      wdt <= 1'h1;
      tick(1);
      wdt <= 1'h0;
      tick(2);
      check(8'(sys_rst), 8'h01, "wdt reset");
      wait_run;
      rd_reg(8'h86, 8'h00, "cause wdt");
      $display("t_wdt done");
   endtask : t_wdt
   task automatic t_flags;
      logic [1:0] s[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
      logic [1:0] l[4] = '{2'h2, 2'h2, 2'h1, 2'h1};
      logic [7:0] e[4] = '{8'h80, 8'h90, 8'h80, 8'ha0};
      for (int i = 0; i < 4; i++)
      begin
         restart(s[i], 1'h1);
         lvl <= l[i];
         tick(10);
         rd_reg(8'h86, e[i], "flags");
         lvl <= 2'h0;
      end
      $display("t_flags done");
   endtask : t_flags
   task automatic t_detector;
      tick(1);
      lvl <= 2'h2;
      tick(8);
      check(8'(sys_rst), 8'h01, "mid reset");
      rd_reg(8'h86, 8'h80, "flags cleared");
      lvl <= 2'h0;
      wait_run;
      restart(2'h0, 1'h1);
      lvl <= 2'h3;
      tick(8);
      check(8'(sys_rst), 8'h01, "low reset");
      check(8'(run), 8'h00, "low held");
      lvl <= 2'h0;
      wait_run;
      $display("t_detector done");
   endtask : t_detector
   task automatic t_gpi;
      restart(2'h0, 1'h0);
      pin_low <= 1'h1;
      slow <= 1'h0;
      tick(8);
      check(8'(sys_rst), 8'h00, "pin ignored");
      check(8'(gpi), 8'h00, "port low");
      pin_low <= 1'h0;
      tick(8);
      check(8'(gpi), 8'h01, "port high");
      $display("t_gpi done");
   endtask : t_gpi
   initial
   begin
      tick(10);
      rst <= 1'h0;
      wait_run;
      t_regs;
      t_pin;
      t_wdt;
      t_flags;
      t_detector;
      t_gpi;
      report_and_stop;
   end
endmodule : rlvc_top_tb
`default_nettype wire
